// [core/adc_clock_divider.v]
// converter clock divider: pclk divided by 2 to the power (select+1), the reserved select 15 dividing as 14
// assumes: select is a settled register value in the pclk domain
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_clock_divider #(
    parameter CNT_WIDTH = 15
) (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [3:0] select,
    output reg adc_clk,
    output reg tick
);

reg [CNT_WIDTH-1:0] cnt;
reg [CNT_WIDTH-1:0] mask;
reg [3:0] sel;

// reserved code falls back to the slowest ratio rather than stopping
always @*
begin
    sel = (select == `CLOCK_DIVIDE_RESERVED) ? `CLOCK_DIVIDE_MAX : select;
    mask = ~({CNT_WIDTH{1'b1}} << (sel + 4'h1));
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cnt <= {CNT_WIDTH{1'b0}};
        adc_clk <= 1'b0;
        tick <= 1'b0;
    end
    else if (!run)
    begin
        cnt <= {CNT_WIDTH{1'b0}};
        adc_clk <= 1'b0;
        tick <= 1'b0;
    end
    else
    begin
        cnt <= cnt + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        adc_clk <= cnt[sel];
        tick <= ((cnt & mask) == mask);
    end
end

endmodule

// [core/adc_seq_consts.vh]
// register indices, field positions, reset values and codes of the a/d sequencer
// assumes: included by its bare name from design and bench files
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_CONVERSION_RESULT 18'h05380
`define IDX_TRIGGER_CHANNEL_CONFIG 18'h05382
`define IDX_CONTROL_STATUS 18'h05384
`define IDX_CONVERTER_CLOCK_DIVIDER 18'h05386

// trigger_channel_config fields
`define LAST_CHANNEL_HI 13
`define LAST_CHANNEL_LO 11
`define FIRST_CHANNEL_HI 10
`define FIRST_CHANNEL_LO 8
`define RESULT_ALIGNMENT_BIT 7
`define REPEAT_MODE_BIT 6
`define TRIGGER_SOURCE_HI 5
`define TRIGGER_SOURCE_LO 4
`define SAMPLE_LENGTH_HI 2
`define SAMPLE_LENGTH_LO 0
`define SAMPLE_LENGTH_RESET 3'h7
`define SAMPLE_EXTRA_CYCLES 4'h2

// trigger source codes
`define TRIG_SOFTWARE 2'h0
`define TRIG_TIMER 2'h1
`define TRIG_EXTERNAL 2'h3

// control_status fields
`define CURRENT_CHANNEL_HI 14
`define CURRENT_CHANNEL_LO 12
`define CONVERTER_BUSY_BIT 10
`define OVERWRITE_ERROR_BIT 9
`define CONVERSION_DONE_BIT 8
`define OVERWRITE_IRQ_ENABLE_BIT 5
`define DONE_IRQ_ENABLE_BIT 4
`define CONVERSION_RUN_BIT 1
`define CONVERTER_ENABLE_BIT 0

// converter_clock_divider
`define CLOCK_DIVIDE_HI 3
`define CLOCK_DIVIDE_LO 0
`define CLOCK_DIVIDE_RESET 4'h0
`define CLOCK_DIVIDE_MAX 4'hE
`define CLOCK_DIVIDE_RESERVED 4'hF

`define RESULT_WIDTH 10
`define RESULT_LEFT_SHIFT 6

`endif

// [core/adc_sequencer_control.v]
// a/d sequencer control: apb registers, trigger selection, channel scan, result store
// assumes: apb master on pclk; converter core on pclk answers convert_start with
// core_done and a 10-bit core_result; external trigger pin is asynchronous, low active
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_sequencer_control (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [19:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire trigger_timer_channel,
    input wire external_trigger_pin_n,
    input wire core_done,
    input wire [9:0] core_result,
    output reg converter_enable,
    output reg adc_clk,
    output reg sample_hold,
    output reg convert_start,
    output reg [2:0] current_channel,
    output reg converter_busy,
    output reg irq_request
);

localparam ST_IDLE = 2'h0;
localparam ST_ARMED = 2'h1;
localparam ST_SAMPLE = 2'h2;
localparam ST_CONVERT = 2'h3;

reg [1:0] state;
reg [1:0] next_state;
reg [2:0] last_channel;
reg [2:0] first_channel;
reg result_alignment;
reg repeat_mode;
reg [1:0] trigger_source;
reg [2:0] sample_length;
reg overwrite_error;
reg conversion_done;
reg overwrite_irq_enable;
reg done_irq_enable;
reg conversion_run;
reg [3:0] clock_divide_select;
reg [9:0] result;
reg [3:0] sample_cnt;
reg ext_sync1;
reg ext_sync2;
reg ext_prev;
reg convert_issued;
reg next_run;
reg next_busy;
reg [2:0] next_channel;
reg [31:0] read_word;
reg addr_hit;
wire div_clk;
wire div_tick;

wire [17:0] word_index = paddr[19:2];
wire access = psel & penable & pready;
wire wr = access & pwrite;
wire rd = access & ~pwrite;
wire wr_cfg = wr & (word_index == `IDX_TRIGGER_CHANNEL_CONFIG);
wire wr_ctl = wr & (word_index == `IDX_CONTROL_STATUS);
wire wr_clk = wr & (word_index == `IDX_CONVERTER_CLOCK_DIVIDER);
wire rd_result = rd & (word_index == `IDX_CONVERSION_RESULT);
wire ext_fall = ext_prev & ~ext_sync2;
wire result_in = (state == ST_CONVERT) & core_done & convert_issued;
wire pass_end = result_in & (current_channel == last_channel);
wire run_written = wr_ctl & pwdata[`CONVERSION_RUN_BIT];
wire stop_written = wr_ctl & ~pwdata[`CONVERSION_RUN_BIT];
wire enable_next = wr_ctl ? pwdata[`CONVERTER_ENABLE_BIT] : converter_enable;

// conversion result shaped by alignment at read time
function [15:0] aligned;
    input [9:0] value;
    input left;
    begin
        if (left)
            aligned = {value, {`RESULT_LEFT_SHIFT{1'b0}}};
        else
            aligned = {{(16-`RESULT_WIDTH){1'b0}}, value};
    end
endfunction

// selected hardware trigger event in this cycle
function trig_hit;
    input [1:0] src;
    input timer_ev;
    input pin_ev;
    begin
        case (src)
            `TRIG_TIMER: trig_hit = timer_ev;
            `TRIG_EXTERNAL: trig_hit = pin_ev;
            default: trig_hit = 1'b0;
        endcase
    end
endfunction

adc_clock_divider #(
    .CNT_WIDTH(15)
) u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .run(converter_enable),
    .select(clock_divide_select),
    .adc_clk(div_clk),
    .tick(div_tick)
);

// pin passes two flops before edge detection
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ext_sync1 <= 1'b1;
        ext_sync2 <= 1'b1;
        ext_prev <= 1'b1;
    end
    else
    begin
        ext_sync1 <= external_trigger_pin_n;
        ext_sync2 <= ext_sync1;
        ext_prev <= ext_sync2;
    end
end

// sequencing decisions
always @*
begin
    next_state = state;
    next_run = conversion_run;
    next_channel = current_channel;
    if (pass_end && !repeat_mode)
        next_run = 1'b0;
    if (wr_ctl)
        next_run = pwdata[`CONVERSION_RUN_BIT];
    case (state)
        ST_IDLE:
        begin
            if (run_written && enable_next)
            begin
                next_channel = first_channel;
                if (trigger_source == `TRIG_SOFTWARE)
                    next_state = ST_SAMPLE;
                else
                    next_state = ST_ARMED;
            end
        end
        ST_ARMED:
        begin
            if (trig_hit(trigger_source, trigger_timer_channel, ext_fall))
                next_state = ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
            if (div_tick && (sample_cnt == {1'b0, sample_length} + `SAMPLE_EXTRA_CYCLES - 4'h1))
                next_state = ST_CONVERT;
        end
        ST_CONVERT:
        begin
            if (result_in)
            begin
                if (current_channel != last_channel)
                begin
                    next_channel = current_channel + 3'h1;
                    next_state = ST_SAMPLE;
                end
                else if (repeat_mode)
                begin
                    next_channel = first_channel;
                    next_state = ST_SAMPLE;
                end
                else
                    next_state = ST_IDLE;
            end
        end
        default:
            next_state = ST_IDLE;
    endcase
    // a stop or a disable ends the scan at once
    if ((stop_written || !enable_next) && state != ST_IDLE)
        next_state = ST_IDLE;
    if (!enable_next)
        next_run = 1'b0;
    next_busy = (next_state == ST_SAMPLE) || (next_state == ST_CONVERT);
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state <= ST_IDLE;
        conversion_run <= 1'b0;
        current_channel <= 3'h0;
        converter_busy <= 1'b0;
        sample_cnt <= 4'h0;
        convert_issued <= 1'b0;
        sample_hold <= 1'b0;
        convert_start <= 1'b0;
        result <= 10'h000;
    end
    else
    begin
        state <= next_state;
        conversion_run <= next_run;
        current_channel <= next_channel;
        converter_busy <= next_busy;
        sample_hold <= (next_state == ST_SAMPLE);
        if (next_state != ST_SAMPLE || state != ST_SAMPLE)
            sample_cnt <= 4'h0;
        else if (div_tick)
            sample_cnt <= sample_cnt + 4'h1;
        convert_start <= (next_state == ST_CONVERT) && (state != ST_CONVERT);
        if (next_state != ST_CONVERT)
            convert_issued <= 1'b0;
        else if (convert_start)
            convert_issued <= 1'b1;
        if (result_in)
            result <= core_result;
    end
end

// flags: a hardware set wins over a software clear in the same cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        conversion_done <= 1'b0;
        overwrite_error <= 1'b0;
    end
    else
    begin
        if (result_in)
            conversion_done <= 1'b1;
        else if (rd_result)
            conversion_done <= 1'b0;
        if (result_in && conversion_done && !rd_result)
            overwrite_error <= 1'b1;
        else if (wr_ctl && pwdata[`OVERWRITE_ERROR_BIT])
            overwrite_error <= 1'b0;
    end
end

// software-written configuration; reserved bits are never stored
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        last_channel <= 3'h0;
        first_channel <= 3'h0;
        result_alignment <= 1'b0;
        repeat_mode <= 1'b0;
        trigger_source <= `TRIG_SOFTWARE;
        sample_length <= `SAMPLE_LENGTH_RESET;
        overwrite_irq_enable <= 1'b0;
        done_irq_enable <= 1'b0;
        converter_enable <= 1'b0;
        clock_divide_select <= `CLOCK_DIVIDE_RESET;
    end
    else
    begin
        if (wr_cfg)
        begin
            last_channel <= pwdata[`LAST_CHANNEL_HI:`LAST_CHANNEL_LO];
            first_channel <= pwdata[`FIRST_CHANNEL_HI:`FIRST_CHANNEL_LO];
            result_alignment <= pwdata[`RESULT_ALIGNMENT_BIT];
            repeat_mode <= pwdata[`REPEAT_MODE_BIT];
            trigger_source <= pwdata[`TRIGGER_SOURCE_HI:`TRIGGER_SOURCE_LO];
            sample_length <= pwdata[`SAMPLE_LENGTH_HI:`SAMPLE_LENGTH_LO];
        end
        if (wr_ctl)
        begin
            overwrite_irq_enable <= pwdata[`OVERWRITE_IRQ_ENABLE_BIT];
            done_irq_enable <= pwdata[`DONE_IRQ_ENABLE_BIT];
            converter_enable <= pwdata[`CONVERTER_ENABLE_BIT];
        end
        if (wr_clk)
            clock_divide_select <= pwdata[`CLOCK_DIVIDE_HI:`CLOCK_DIVIDE_LO];
    end
end

// read multiplexer; unlisted bits stay zero
always @*
begin
    read_word = 32'h00000000;
    addr_hit = 1'b1;
    case (word_index)
        `IDX_CONVERSION_RESULT:
            read_word[15:0] = aligned(result, result_alignment);
        `IDX_TRIGGER_CHANNEL_CONFIG:
        begin
            read_word[`LAST_CHANNEL_HI:`LAST_CHANNEL_LO] = last_channel;
            read_word[`FIRST_CHANNEL_HI:`FIRST_CHANNEL_LO] = first_channel;
            read_word[`RESULT_ALIGNMENT_BIT] = result_alignment;
            read_word[`REPEAT_MODE_BIT] = repeat_mode;
            read_word[`TRIGGER_SOURCE_HI:`TRIGGER_SOURCE_LO] = trigger_source;
            read_word[`SAMPLE_LENGTH_HI:`SAMPLE_LENGTH_LO] = sample_length;
        end
        `IDX_CONTROL_STATUS:
        begin
            read_word[`CURRENT_CHANNEL_HI:`CURRENT_CHANNEL_LO] = current_channel;
            read_word[`CONVERTER_BUSY_BIT] = converter_busy;
            read_word[`OVERWRITE_ERROR_BIT] = overwrite_error;
            read_word[`CONVERSION_DONE_BIT] = conversion_done;
            read_word[`OVERWRITE_IRQ_ENABLE_BIT] = overwrite_irq_enable;
            read_word[`DONE_IRQ_ENABLE_BIT] = done_irq_enable;
            read_word[`CONVERSION_RUN_BIT] = conversion_run;
            read_word[`CONVERTER_ENABLE_BIT] = converter_enable;
        end
        `IDX_CONVERTER_CLOCK_DIVIDER:
            read_word[`CLOCK_DIVIDE_HI:`CLOCK_DIVIDE_LO] = clock_divide_select;
        default:
            addr_hit = 1'b0;
    endcase
end

// one wait state keeps prdata and pready straight from flops
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        adc_clk <= 1'b0;
        irq_request <= 1'b0;
    end
    else
    begin
        pready <= psel & penable & ~pready;
        if (psel && penable && !pready)
        begin
            pslverr <= ~addr_hit;
            prdata <= pwrite ? 32'h00000000 : read_word;
        end
        else
        begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        adc_clk <= div_clk;
        irq_request <= (overwrite_error & overwrite_irq_enable) |
                       (conversion_done & done_irq_enable);
    end
end

endmodule

// [tb/adc_core_model.sv]
// converter core stand-in: answers each convert_start after a random delay
// assumes: same pclk domain; result lines only valid with core_done
`timescale 1ns/1ps
module adc_core_model (
    input wire pclk,
    input wire presetn,
    input wire converter_enable,
    input wire convert_start,
    output reg core_done,
    output reg [9:0] core_result,
    output reg [9:0] last_value
);
    integer left;
    reg [9:0] v;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_done <= 1'h0;
            core_result <= 10'h2AA;
            last_value <= 10'h0;
            left <= 0;
        end
        else
        begin
            v = $urandom;
            core_done <= 1'h0;
            // no stale value outside a done pulse
            core_result <= ~core_result;
            if (!converter_enable)
                left <= 0;
            else if (convert_start)
                left <= 1 + $urandom % 6; // prompt or slow answer
            else if (left == 1)
            begin
                core_done <= 1'h1;
                core_result <= v;
                last_value <= v;
                left <= 0;
            end
            else if (left > 1)
                left <= left - 1;
        end
    end
endmodule

// [tb/adc_seq_properties.sv]
// port checker for the a/d sequencer control block
// assumes: bound into adc_sequencer_control from the bench top
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module adc_seq_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [19:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire converter_enable,
    input wire adc_clk,
    input wire sample_hold,
    input wire convert_start,
    input wire converter_busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire rd_ok = pready && !pwrite;
    a_apb_one_wait:
        assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb answer off");
    a_cfg_reserved:
        assert property (rd_ok && paddr[19:2] == `IDX_TRIGGER_CHANNEL_CONFIG |-> prdata[31:14] == 0 && !prdata[3])
        else $error("config reserved bits set");
    a_result_zeros:
        assert property (rd_ok && paddr[19:2] == `IDX_CONVERSION_RESULT |->
            prdata[31:16] == 0 && (prdata[15:10] == 0 || prdata[5:0] == 0))
        else $error("result padding wrong");
    a_start_once:
        assert property (convert_start |=> !convert_start)
        else $error("start pulse too long");
    a_start_sampled:
        assert property (convert_start |-> $past(sample_hold))
        else $error("start without sampling");
    a_sample_min:
        assert property ($rose(sample_hold) ##1 converter_busy ##1 converter_busy |-> sample_hold && $past(sample_hold))
        else $error("sampling cut short");
    a_busy_sample:
        assert property (sample_hold |-> converter_busy)
        else $error("sampling while idle");
    a_enable_busy:
        assert property (converter_busy |-> converter_enable)
        else $error("busy while disabled");
    a_clk_idle:
        assert property (!converter_enable [*3] |-> !adc_clk)
        else $error("converter clock runs while disabled");
endmodule

// [tb/tb_adc_sequencer_control.sv]
// bench for the a/d sequencer control block
// assumes: core model on the converter side, apb master here
`timescale 1ns/1ps
`include "adc_seq_consts.vh"
module tb_adc_sequencer_control;
    reg pclk = 0;
    reg presetn = 0;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [19:0] paddr = 20'h0;
    reg [31:0] pwdata = 32'h0;
    reg trigger_timer_channel = 0;
    reg external_trigger_pin_n = 1;
    wire [31:0] prdata;
    wire pready, pslverr, core_done, converter_enable, adc_clk;
    wire sample_hold, convert_start, converter_busy, irq_request;
    wire [9:0] core_result, last_value;
    wire [2:0] current_channel;
    reg [31:0] r;
    reg err;
    reg [1:0] src;
    reg [2:0] f, len;
    reg [3:0] ck;
    reg [2:0] chq[$];
    integer fails = 0, samples_checked = 0, i, k, n, hl = 0, hlen = 0;
    localparam [19:0] A_RES = {`IDX_CONVERSION_RESULT, 2'h0};
    localparam [19:0] A_CFG = {`IDX_TRIGGER_CHANNEL_CONFIG, 2'h0};
    localparam [19:0] A_CTL = {`IDX_CONTROL_STATUS, 2'h0};
    localparam [19:0] A_DIV = {`IDX_CONVERTER_CLOCK_DIVIDER, 2'h0};
    initial forever #2 pclk = ~pclk;
    adc_sequencer_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_timer_channel(trigger_timer_channel),
        .external_trigger_pin_n(external_trigger_pin_n), .core_done(core_done),
        .core_result(core_result), .converter_enable(converter_enable), .adc_clk(adc_clk),
        .sample_hold(sample_hold), .convert_start(convert_start), .current_channel(current_channel),
        .converter_busy(converter_busy), .irq_request(irq_request));
    adc_core_model core (.pclk(pclk), .presetn(presetn), .converter_enable(converter_enable),
        .convert_start(convert_start), .core_done(core_done), .core_result(core_result),
        .last_value(last_value));
    // sampling length and channel order seen at the core side
    always @(posedge pclk)
    begin
        hl <= sample_hold ? hl + 1 : 0;
        if (convert_start)
        begin
            hlen <= hl;
            chq.push_back(current_channel);
        end
    end
    task complete_run;
        begin
            if (fails == 0 && samples_checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked++;
            if (got !== exp)
            begin
                fails++;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task hang;
        begin
            fails++;
            complete_run;
        end
    endtask
    // one transfer; the request stands until pready is sampled high
    task apb(input w, input [19:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 20);
            if (pready !== 1'b1)
                hang;
            r = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task wr(input [19:0] a, input [31:0] d);
        apb(1, a, d);
    endtask
    task rd(input [19:0] a, input [31:0] e);
        begin
            apb(0, a, 32'h0);
            chk(r, e);
        end
    endtask
    // channel field moves with the scan, so it is masked here
    task rdc(input [31:0] e);
        begin
            apb(0, A_CTL, 32'h0);
            chk(r & 32'hFFFF8FFF, e);
        end
    endtask
    task kick(input [1:0] s);
        begin
            if (s == `TRIG_TIMER)
            begin
                @(posedge pclk) trigger_timer_channel <= 1;
                @(posedge pclk) trigger_timer_channel <= 0;
            end
            else if (s == `TRIG_EXTERNAL)
            begin
                @(posedge pclk) external_trigger_pin_n <= 0;
                repeat (3) @(posedge pclk);
                external_trigger_pin_n <= 1;
            end
        end
    endtask
    task wait_idle;
        begin
            n = 0;
            repeat (4) @(posedge pclk);
            while (converter_busy !== 1'b0 && n < 2000)
            begin
                @(posedge pclk);
                n++;
            end
            if (converter_busy !== 1'b0)
                hang;
            repeat (2) @(posedge pclk);
        end
    endtask
    initial
    begin
        r = $urandom(8);
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rd(A_RES, 32'h0);
        rd(A_CFG, 32'h7);
        rd(A_CTL, 32'h0);
        rd(A_DIV, 32'h0);
        rd(20'h00100, 32'h0);
        chk(err, 1);
        wr(A_CFG, 32'hFFFFFFFF);
        rd(A_CFG, 32'h3FF7);
        wr(A_DIV, 32'hFFFFFFF3);
        rd(A_DIV, 32'h3);
        wr(A_DIV, 32'h0);
        wr(A_CTL, 32'hFFFFFFFC);
        rdc(32'h30);
        for (i = 0; i < 6; i++)
        begin
            src = i % 3 == 0 ? `TRIG_SOFTWARE : i % 3 == 1 ? `TRIG_TIMER : `TRIG_EXTERNAL;
            f = $urandom;
            len = i == 0 ? 3'h0 : i == 1 ? 3'h7 : $urandom;
            wr(A_CFG, {18'h0, f, f, i > 2, 1'b0, src, 1'b0, len});
            wr(A_CTL, 32'h33);
            kick(src);
            wait_idle;
            chk(hlen >= 2 * len + 3 && hlen <= 2 * len + 5, 1);
            chk(irq_request, 1);
            rdc(32'h131);
            rd(A_RES, i > 2 ? {16'h0, last_value, 6'h0} : {22'h0, last_value});
            rdc(32'h31);
        end
        // start above end wraps through 7, four results unread
        chq.delete();
        wr(A_CFG, 32'h0E00);
        wr(A_CTL, 32'h33);
        wait_idle;
        chk(chq.size(), 4);
        for (k = 0; k < 4; k++)
            chk(chq[k], (6 + k) % 8);
        rdc(32'h331);
        wr(A_CTL, 32'h31);
        rdc(32'h331);
        wr(A_CTL, 32'h231);
        rdc(32'h131);
        chq.delete();
        wr(A_CFG, 32'h1A40);
        // divide by 4 while scanning, so a non-zero select is exercised
        wr(A_DIV, 32'h1);
        wr(A_CTL, 32'h3);
        n = 0;
        while (chq.size() < 5 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        if (chq.size() < 5)
            hang;
        // period four: samples two cycles apart are inverted
        for (k = 0; k < 4; k++)
        begin
            @(posedge pclk);
            ck[k] = adc_clk;
        end
        chk({ck[0] ^ ck[2], ck[1] ^ ck[3]}, 32'h3);
        wr(A_CTL, 32'h1);
        repeat (2) @(posedge pclk);
        chk(converter_busy, 0);
        chk(irq_request, 0);
        for (k = 0; k < 5; k++)
            chk(chq[k], 2 + k % 2);
        chk(converter_enable, 1);
        wr(A_CTL, 32'h0);
        repeat (2) @(posedge pclk);
        chk(converter_enable, 0);
        complete_run;
    end
endmodule
bind adc_sequencer_control adc_seq_props props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .converter_enable(converter_enable), .adc_clk(adc_clk), .sample_hold(sample_hold),
    .convert_start(convert_start), .converter_busy(converter_busy));
